//--- inc/lock_pkg.sv
package lock_pkg;

    // ------------------------------------------------------------
    // Service codes and response service codes
    // ------------------------------------------------------------
    localparam logic [7:0] SVC_ACQUIRE = 8'h4e;
    localparam logic [7:0] SVC_UPDATE = 8'h4f;
    localparam logic [7:0] SVC_RELEASE = 8'h50;
    localparam logic [7:0] SVC_WRITE = 8'h10;
    localparam logic [7:0] SVC_REPLY_BIT = 8'h80;
    localparam logic [7:0] SVC_ERR_REPLY = 8'h94;

    // ------------------------------------------------------------
    // General and additional status codes
    // ------------------------------------------------------------
    localparam logic [7:0] GS_OK = 8'h00;
    localparam logic [7:0] GS_SVC_UNSUP = 8'h08;
    localparam logic [7:0] GS_STATE_CONFLICT = 8'h0c;
    localparam logic [7:0] GS_INVALID_PARAM = 8'h20;
    localparam logic [7:0] GS_NOT_SETTABLE_NOW = 8'h27;
    localparam logic [7:0] GS_BAD_MEMBER = 8'h28;
    localparam logic [7:0] GS_MEMBER_RO = 8'h29;
    localparam logic [7:0] GS_SMALL_SERVER = 8'h2a;
    localparam logic [7:0] GS_CLASS_SPECIFIC = 8'hd0;
    localparam logic [7:0] ADD_NONE = 8'h00;
    localparam logic [7:0] ADD_FF = 8'hff;

    // ------------------------------------------------------------
    // Instances, program numbers, area layout
    // ------------------------------------------------------------
    localparam logic [15:0] INST_AREA0 = 16'h0010;
    localparam logic [15:0] INST_AREA1 = 16'h0011;
    localparam logic [15:0] PROG_SHARED = 16'h0000;
    localparam logic [15:0] PROG_FORCE = 16'hffff;
    localparam int AREA_WORDS = 16;
    localparam int WORD_W = 16;
    localparam logic [7:0] MEMBER_RO = 8'h0f;
    localparam logic [3:0] LAST_WORD = 4'hf;

    // ------------------------------------------------------------
    // Monitor timer
    // ------------------------------------------------------------
    localparam logic [15:0] TMR_MAX = 16'h0258;
    localparam logic [9:0] TMR_DEFAULT = 10'h064;
    localparam logic [9:0] TMR_RESET = 10'h000;
    localparam int TICK_NS = 100_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Clear sweep states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_CLEAR = 2'b10
    } sweep_state_t;

endpackage : lock_pkg

//--- hw/area_store.sv
// Storage for both target output areas; read data is registered
module area_store (
    // Clock
    input wire logic ref_clk,
    input wire logic ce,
    // Write port
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [15:0] wr_data,
    // Read port
    input wire logic [4:0] rd_addr,
    output logic [15:0] rd_data
);

    logic [15:0] mem [0:2*lock_pkg::AREA_WORDS-1];

    // Write side, frozen with the clock enable
    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, one cycle of latency
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : area_store

//--- hw/output_area_access_lock.sv
// What this block does
// - Report status 27 for a set that cannot be done right now.
// - Report status 28 when the named member does not exist.
// - Report status 29 when the member cannot be modified.
// - Status 2A only from small servers, replacing unsupported codes.
// - Codes 2C-2F reserved; D0-FF only for class-specific errors.
// - Refuse message writes to an area busy with cyclic traffic.
// - Ownership keyed on client program number; clients keep numbers unique.
// - Acquire stores program number and monitor time; others then refused.
// - Refuse acquire from a different number while the right is held.
// - Timeout releases the right and clears the area to zeros.
// - Writes accepted in idle mode; the monitor timer keeps running.
// - Timeout errors shown; cleared only while in run mode.
// - Program number 0 skips ownership checks except on acquire, runs only the timer.
// - Update from the holder restarts the monitor timer.
// - Accepted data write restarts the monitor timer too.
// - Program number FFFF writes regardless of ownership.
// - Release frees the right and stops the monitor timer.
// - Release leaves the written data unchanged.
// - Timer in 100 ms units, 1 to 258 hex, 0 means 10 s.
// - Acquire is 4E; success echoes with top bit, error returns 94.
// - Acquire refused as held gives 0C with additional FF.
// - Areas are instances 10 and 11; others out of range.
module output_area_access_lock #(
    parameter int TICK_CYCLES = lock_pkg::TICK_CYCLES,
    parameter bit SMALL_SERVER = 1'b0
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_service,
    input wire logic [15:0] req_instance,
    input wire logic [15:0] req_prog,
    input wire logic [15:0] req_timer,
    input wire logic [7:0] req_member,
    input wire logic [15:0] req_data,
    // Response
    output logic rsp_valid,
    output logic [7:0] rsp_service,
    output logic [7:0] rsp_gen_status,
    output logic [7:0] rsp_add_status,
    // Controller state
    input wire logic [1:0] cyclic_active,
    input wire logic run_mode,
    input wire logic err_clear,
    // Area status
    output logic [1:0] area_held,
    output logic [1:0] area_armed,
    output logic [1:0] timeout_err,
    // Output data read port
    input wire logic [4:0] out_rd_addr,
    output logic [15:0] out_rd_data
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] pre_ff;
    logic tick;
    logic [1:0] held_ff;
    logic [1:0] armed_ff;
    logic [15:0] holder_ff [0:1];
    logic [9:0] tmr_ff [0:1];
    logic [9:0] set_ff [0:1];
    logic [1:0] expire;
    logic [1:0] pend_ff;
    logic [1:0] err_ff;
    lock_pkg::sweep_state_t state_ff;
    logic clr_area_ff;
    logic [3:0] clr_idx_ff;
    logic take;
    logic area;
    logic inst_ok;
    logic other_owner;
    logic [7:0] nxt_gen;
    logic [7:0] nxt_add;
    logic do_acq;
    logic do_upd;
    logic do_rel;
    logic do_wr;
    logic [9:0] load_val;
    logic rsp_valid_ff;
    logic [7:0] rsp_service_ff;
    logic [7:0] rsp_gen_ff;
    logic [7:0] rsp_add_ff;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;

    // Converts a requested set value; 0 selects the default
    function automatic logic [9:0] timer_load(input logic [15:0] set_val);
        timer_load = (set_val == 16'h0000) ? lock_pkg::TMR_DEFAULT : set_val[9:0];
    endfunction : timer_load

    // ------------------------------------------------------------
    // Monitor time base
    // ------------------------------------------------------------
    // One shared 100 ms prescaler; a restart lands anywhere inside a unit,
    // so a timeout may come up to one unit early. Traded for one counter.
    // 100 ms unit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pre_ff <= 32'h0;
        end else if (ce) begin
            pre_ff <= tick ? 32'h0 : pre_ff + 32'h1;
        end
    end

    assign tick = (pre_ff == 32'(TICK_CYCLES - 1));

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            expire[i] = armed_ff[i] && tick && (tmr_ff[i] == 10'h001);
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Stalled during expiry or sweep, so no request races the release
    assign req_ready = ce && (state_ff == lock_pkg::ST_RUN) && (expire == 2'b00)
        && (pend_ff == 2'b00);
    assign take = req_valid && req_ready;
    assign area = req_instance[0];
    assign inst_ok = (req_instance == lock_pkg::INST_AREA0)
        || (req_instance == lock_pkg::INST_AREA1);
    assign other_owner = held_ff[area] && (req_prog != holder_ff[area]);
    assign load_val = timer_load(req_timer);
    assign nxt_add = (nxt_gen == lock_pkg::GS_OK) ? lock_pkg::ADD_NONE : lock_pkg::ADD_FF;

    // Checks in priority order; the first failing check names the status
    always_comb begin
        nxt_gen = lock_pkg::GS_OK;
        do_acq = 1'b0;
        do_upd = 1'b0;
        do_rel = 1'b0;
        do_wr = 1'b0;
        case (req_service)
            lock_pkg::SVC_ACQUIRE: begin
                if (!inst_ok || (req_prog == lock_pkg::PROG_FORCE)
                        || (req_timer > lock_pkg::TMR_MAX)) begin
                    nxt_gen = lock_pkg::GS_INVALID_PARAM;
                end else if (other_owner) begin
                    nxt_gen = lock_pkg::GS_STATE_CONFLICT;
                end else begin
                    do_acq = 1'b1;
                end
            end
            lock_pkg::SVC_UPDATE: begin
                if (!inst_ok) begin
                    nxt_gen = lock_pkg::GS_INVALID_PARAM;
                end else if (!armed_ff[area]) begin
                    nxt_gen = lock_pkg::GS_CLASS_SPECIFIC;
                end else if (other_owner && (req_prog != lock_pkg::PROG_SHARED)) begin
                    nxt_gen = lock_pkg::GS_STATE_CONFLICT;
                end else begin
                    do_upd = 1'b1;
                end
            end
            lock_pkg::SVC_RELEASE: begin
                if (!inst_ok) begin
                    nxt_gen = lock_pkg::GS_INVALID_PARAM;
                end else if (other_owner && (req_prog != lock_pkg::PROG_SHARED)) begin
                    nxt_gen = lock_pkg::GS_STATE_CONFLICT;
                end else begin
                    do_rel = 1'b1;
                end
            end
            lock_pkg::SVC_WRITE: begin
                if (!inst_ok) begin
                    nxt_gen = lock_pkg::GS_INVALID_PARAM;
                end else if (cyclic_active[area]) begin
                    nxt_gen = lock_pkg::GS_NOT_SETTABLE_NOW;
                end else if (req_member >= 8'(lock_pkg::AREA_WORDS)) begin
                    nxt_gen = lock_pkg::GS_BAD_MEMBER;
                end else if (req_member == lock_pkg::MEMBER_RO) begin
                    nxt_gen = lock_pkg::GS_MEMBER_RO;
                end else if (other_owner && (req_prog != lock_pkg::PROG_SHARED)
                        && (req_prog != lock_pkg::PROG_FORCE)) begin
                    nxt_gen = lock_pkg::GS_STATE_CONFLICT;
                end else begin
                    do_wr = 1'b1;
                end
            end
            default: begin
                nxt_gen = SMALL_SERVER ? lock_pkg::GS_SMALL_SERVER : lock_pkg::GS_SVC_UNSUP;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Per-area right and monitor timer
    // ------------------------------------------------------------
    // independent areas
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            held_ff <= 2'b00;
            armed_ff <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                holder_ff[i] <= lock_pkg::PROG_SHARED;
                tmr_ff[i] <= lock_pkg::TMR_RESET;
                set_ff[i] <= lock_pkg::TMR_RESET;
            end
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (expire[i]) begin
                    held_ff[i] <= 1'b0;
                    armed_ff[i] <= 1'b0;
                end else if (take && (area == 1'(i)) && do_acq) begin
                    held_ff[i] <= (req_prog != lock_pkg::PROG_SHARED);
                    armed_ff[i] <= 1'b1;
                    holder_ff[i] <= req_prog;
                    tmr_ff[i] <= load_val;
                    set_ff[i] <= load_val;
                end else if (take && (area == 1'(i)) && do_rel) begin
                    held_ff[i] <= 1'b0;
                    armed_ff[i] <= 1'b0;
                end else if (take && (area == 1'(i)) && (do_upd || do_wr) && armed_ff[i]) begin
                    tmr_ff[i] <= set_ff[i];
                end else if (tick && armed_ff[i]) begin
                    tmr_ff[i] <= tmr_ff[i] - 10'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Timeout clear sweep
    // ------------------------------------------------------------
    // Pending flags: a new expiry wins over the finish of a sweep
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_ff <= 2'b00;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (expire[i]) begin
                    pend_ff[i] <= 1'b1;
                end else if ((state_ff == lock_pkg::ST_CLEAR) && (clr_area_ff == 1'(i))
                        && (clr_idx_ff == lock_pkg::LAST_WORD)) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    // One word per cycle; area 0 is swept first if both expired
    // zero the area
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= lock_pkg::ST_RUN;
            clr_area_ff <= 1'b0;
            clr_idx_ff <= 4'h0;
        end else if (ce) begin
            unique case (state_ff)
                lock_pkg::ST_RUN: begin
                    if (pend_ff != 2'b00) begin
                        state_ff <= lock_pkg::ST_CLEAR;
                        clr_area_ff <= !pend_ff[0];
                        clr_idx_ff <= 4'h0;
                    end
                end
                lock_pkg::ST_CLEAR: begin
                    clr_idx_ff <= clr_idx_ff + 4'h1;
                    if (clr_idx_ff == lock_pkg::LAST_WORD) begin
                        state_ff <= lock_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_ff <= lock_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Timeout error flags
    // ------------------------------------------------------------
    // Set wins over clear; idle mode cannot clear
    // run-mode clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            err_ff <= 2'b00;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (expire[i]) begin
                    err_ff[i] <= 1'b1;
                end else if (err_clear && run_mode) begin
                    err_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    // reply service code
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_service_ff <= 8'h00;
            rsp_gen_ff <= lock_pkg::GS_OK;
            rsp_add_ff <= lock_pkg::ADD_NONE;
        end else if (ce) begin
            rsp_valid_ff <= take;
            if (take) begin
                rsp_service_ff <= (nxt_gen == lock_pkg::GS_OK)
                    ? (req_service | lock_pkg::SVC_REPLY_BIT) : lock_pkg::SVC_ERR_REPLY;
                rsp_gen_ff <= nxt_gen;
                rsp_add_ff <= nxt_add;
            end
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_service = rsp_service_ff;
    assign rsp_gen_status = rsp_gen_ff;
    assign rsp_add_status = rsp_add_ff;
    assign area_held = held_ff;
    assign area_armed = armed_ff;
    assign timeout_err = err_ff;

    // ------------------------------------------------------------
    // Area data
    // ------------------------------------------------------------
    // Sweep owns the write port; requests are stalled meanwhile.
    // release never writes
    assign wr_en = (state_ff == lock_pkg::ST_CLEAR) || (take && do_wr);
    assign wr_addr = (state_ff == lock_pkg::ST_CLEAR) ? {clr_area_ff, clr_idx_ff}
        : {area, req_member[3:0]};
    assign wr_data = (state_ff == lock_pkg::ST_CLEAR) ? 16'h0000 : req_data;

    area_store u_store (
        .ref_clk(ref_clk),
        .ce(ce),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(out_rd_addr),
        .rd_data(out_rd_data)
    );

endmodule : output_area_access_lock

//--- test/area_lock_props.sv
module area_lock_props #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [7:0] req_service,
    input wire logic [15:0] req_instance,
    input wire logic [15:0] req_prog,
    input wire logic [7:0] req_member,
    // Response
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_service,
    input wire logic [7:0] rsp_gen_status,
    input wire logic [7:0] rsp_add_status,
    // Controller state and flags
    input wire logic [1:0] cyclic_active,
    input wire logic run_mode,
    input wire logic err_clear,
    input wire logic [1:0] area_armed,
    input wire logic [1:0] timeout_err
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Shared request qualifiers
    logic taken;
    logic inst_ok;
    logic wr_free;
    assign taken = req_valid && req_ready;
    assign inst_ok = req_instance == 16'h0010 || req_instance == 16'h0011;
    assign wr_free = taken && inst_ok && req_service == 8'h10 && !cyclic_active[req_instance[0]];

    sequence ok_reply;
        taken ##1 (rsp_gen_status == 8'h00);
    endsequence
    sequence release_ok;
        (taken && req_service == 8'h50 && req_instance == 16'h0010) ##1 (rsp_gen_status == 8'h00);
    endsequence

    chk_rsp_next: assert property (taken |=> rsp_valid)
        else $error("no response one cycle after a taken request");
    chk_err_codes: assert property (rsp_valid && rsp_gen_status != 8'h00 |->
        rsp_service == 8'h94 && rsp_add_status == 8'hff)
        else $error("error reply has wrong service or additional code");
    chk_ok_echo: assert property (ok_reply |-> rsp_service == ($past(req_service) | 8'h80))
        else $error("success reply does not echo the service");
    chk_no_reserved: assert property (rsp_valid |-> !(rsp_gen_status inside {[8'h2c:8'h2f]}))
        else $error("reserved general status returned");
    chk_bad_inst: assert property (taken && !inst_ok && req_service inside {8'h4e, 8'h4f, 8'h50,
        8'h10} |=> rsp_gen_status == 8'h20)
        else $error("bad instance not answered with 20");
    chk_cyclic_busy: assert property (taken && inst_ok && req_service == 8'h10 &&
        cyclic_active[req_instance[0]] |=> rsp_gen_status == 8'h27)
        else $error("write to cyclic area not refused with 27");
    chk_force_write: assert property (wr_free && req_member < 8'h0f &&
        req_prog == 16'hffff |=> rsp_gen_status == 8'h00)
        else $error("forced write refused");
    chk_member_codes: assert property (wr_free && req_member >= 8'h0f |=>
        rsp_gen_status == (($past(req_member) == 8'h0f) ? 8'h29 : 8'h28))
        else $error("member code wrong");
    chk_release_stop: assert property (release_ok |-> !area_armed[0])
        else $error("timer still armed after release");
    chk_clear_run: assert property ($past(rst_n) && ($fell(timeout_err[0]) ||
        $fell(timeout_err[1])) |-> $past(run_mode && err_clear))
        else $error("timeout error cleared outside run mode");
endmodule : area_lock_props

bind output_area_access_lock area_lock_props #(.TICK_CYCLES(TICK_CYCLES)) area_lock_props_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_service(req_service), .req_instance(req_instance), .req_prog(req_prog),
    .req_member(req_member), .rsp_valid(rsp_valid), .rsp_service(rsp_service),
    .rsp_gen_status(rsp_gen_status), .rsp_add_status(rsp_add_status),
    .cyclic_active(cyclic_active), .run_mode(run_mode), .err_clear(err_clear),
    .area_armed(area_armed), .timeout_err(timeout_err)
);

//--- test/msg_client.sv
module msg_client (
    // Clock
    input wire logic ref_clk,
    // Request
    output logic req_valid,
    input wire logic req_ready,
    output logic [7:0] req_service,
    output logic [15:0] req_instance,
    output logic [15:0] req_prog,
    output logic [15:0] req_timer,
    output logic [7:0] req_member,
    output logic [15:0] req_data,
    // Response
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_service,
    input wire logic [7:0] rsp_gen_status,
    input wire logic [7:0] rsp_add_status
);
    timeunit 1ns;
    timeprecision 100ps;
    logic late;
    logic [24:0] got;

    // Idle at time zero
    initial begin
        req_valid = 1'b0;
        {req_service, req_instance, req_prog, req_timer, req_member, req_data} = '0;
        late = 1'b0;
        got = '0;
    end

    task send(input logic [7:0] svc, input logic [15:0] inst, input logic [15:0] prog,
              input logic [15:0] tmr, input logic [7:0] mem, input logic [15:0] dat);
        int n;
        @(negedge ref_clk);
        {req_service, req_instance, req_prog} = {svc, inst, prog};
        {req_timer, req_member, req_data} = {tmr, mem, dat};
        req_valid = 1'b1;
        late = 1'b1;
        for (n = 0; n < 40 && late; n++) begin
            #1;
            if (req_ready === 1'b1) late = 1'b0;
            else @(negedge ref_clk);
        end
        @(posedge ref_clk);
        // Released fields flip so a stale value never passes for a live one
        @(negedge ref_clk);
        req_valid = 1'b0;
        {req_service, req_instance, req_prog} = ~{req_service, req_instance, req_prog};
        {req_timer, req_member, req_data} = ~{req_timer, req_member, req_data};
        got = {rsp_valid, rsp_service, rsp_gen_status, rsp_add_status};
    endtask : send
endmodule : msg_client

//--- test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, run_mode = 1'b1, err_clear = 1'b0;
    logic [1:0] cyclic_active = 2'b00;
    logic [4:0] out_rd_addr = 5'h00;
    logic req_valid, req_ready, rsp_valid;
    logic [7:0] req_service, req_member, rsp_service, rsp_gen_status, rsp_add_status;
    logic [15:0] req_instance, req_prog, req_timer, req_data, out_rd_data;
    logic [1:0] area_held, area_armed, timeout_err;
    logic [31:0] lfsr = 32'hb2154754;
    int n_errors = 0, tests_run = 0;

    output_area_access_lock #(.TICK_CYCLES(4), .SMALL_SERVER(1'b0)) output_area_access_lock_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
        .req_service(req_service), .req_instance(req_instance), .req_prog(req_prog),
        .req_timer(req_timer), .req_member(req_member), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_service(rsp_service), .rsp_gen_status(rsp_gen_status),
        .rsp_add_status(rsp_add_status), .cyclic_active(cyclic_active), .run_mode(run_mode),
        .err_clear(err_clear), .area_held(area_held), .area_armed(area_armed),
        .timeout_err(timeout_err), .out_rd_addr(out_rd_addr), .out_rd_data(out_rd_data));
    msg_client msg_client_i (
        .ref_clk(ref_clk), .req_valid(req_valid), .req_ready(req_ready),
        .req_service(req_service), .req_instance(req_instance), .req_prog(req_prog),
        .req_timer(req_timer), .req_member(req_member), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_service(rsp_service), .rsp_gen_status(rsp_gen_status),
        .rsp_add_status(rsp_add_status));

    // 250 MHz clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    function logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected reply service code
    function logic [7:0] exp_svc(input logic [7:0] svc, input logic [7:0] gen);
        return (gen === 8'h00) ? (svc | lock_pkg::SVC_REPLY_BIT) : lock_pkg::SVC_ERR_REPLY;
    endfunction : exp_svc

    task chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task chk_rsp(input logic [7:0] svc, input logic [7:0] gen);
        logic [24:0] exp;
        exp = {1'b1, exp_svc(svc, gen), gen, (gen === 8'h00) ? 8'h00 : 8'hff};
        tests_run++;
        if (msg_client_i.late !== 1'b0 || msg_client_i.got !== exp) begin
            n_errors++;
            $display("wrong value response expected %h seen %h", exp, msg_client_i.got);
        end
    endtask : chk_rsp
    task go(input logic [7:0] svc, input logic [15:0] inst, input logic [15:0] prog,
            input logic [15:0] tmr, input logic [7:0] mem, input logic [15:0] dat,
            input logic [7:0] gen);
        msg_client_i.send(svc, inst, prog, tmr, mem, dat);
        chk_rsp(svc, gen);
    endtask : go
    task rd(input logic [4:0] a, input logic [15:0] exp);
        @(negedge ref_clk) out_rd_addr = a;
        @(negedge ref_clk);
        chk_val("area word", exp, out_rd_data);
    endtask : rd
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    // Hang guard
    initial begin
        #200000;
        n_errors++;
        print_verdict;
    end

    // Main sequence
    initial begin
        int n;
        logic [7:0] mem;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        go(8'h4e, 16'h10, 16'h5, 16'h0, 8'h0, 16'h0, 8'h00);
        chk_val("held", 16'h1, {14'h0, area_held});
        go(8'h4e, 16'h10, 16'h6, 16'h3, 8'h0, 16'h0, 8'h0c);
        go(8'h10, 16'h10, 16'h6, 16'h0, 8'h2, 16'h1234, 8'h0c);
        go(8'h10, 16'h10, 16'h5, 16'h0, 8'h1, 16'ha5a5, 8'h00);
        go(8'h10, 16'h10, 16'h0, 16'h0, 8'h2, 16'h0f0f, 8'h00);
        go(8'h10, 16'h10, 16'hffff, 16'h0, 8'h3, 16'h5aa5, 8'h00);
        rd(5'h02, 16'h0f0f);
        rd(5'h03, 16'h5aa5);
        $display("test ownership done");
        go(8'h4e, 16'h12, 16'h5, 16'h0, 8'h0, 16'h0, 8'h20);
        go(8'h4e, 16'h11, 16'h6, 16'h259, 8'h0, 16'h0, 8'h20);
        go(8'h4f, 16'h11, 16'h6, 16'h0, 8'h0, 16'h0, 8'hd0);
        go(8'h10, 16'h10, 16'h5, 16'h0, 8'h10, 16'h0, 8'h28);
        go(8'h10, 16'h10, 16'h5, 16'h0, 8'h0f, 16'h0, 8'h29);
        go(8'h33, 16'h10, 16'h5, 16'h0, 8'h0, 16'h0, 8'h08);
        @(negedge ref_clk) cyclic_active = 2'b01;
        go(8'h10, 16'h10, 16'h5, 16'h0, 8'h1, 16'h0, 8'h27);
        @(negedge ref_clk) cyclic_active = 2'b00;
        $display("test refusals done");
        go(8'h50, 16'h10, 16'h5, 16'h0, 8'h0, 16'h0, 8'h00);
        chk_val("armed", 16'h0, {14'h0, area_armed});
        rd(5'h01, 16'ha5a5);
        @(negedge ref_clk) run_mode = 1'b0;
        go(8'h4e, 16'h11, 16'h6, 16'h2, 8'h0, 16'h0, 8'h00);
        go(8'h4f, 16'h11, 16'h6, 16'h0, 8'h0, 16'h0, 8'h00);
        go(8'h10, 16'h11, 16'h6, 16'h0, 8'h4, 16'hbeef, 8'h00);
        n = 0;
        while (area_held[1] !== 1'b0 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk_val("held after timeout", 16'h0, {14'h0, area_held});
        chk_val("timeout error", 16'h2, {14'h0, timeout_err});
        repeat (20) @(negedge ref_clk);
        rd(5'h14, 16'h0000);
        @(negedge ref_clk) err_clear = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_val("error kept in idle", 16'h2, {14'h0, timeout_err});
        run_mode = 1'b1;
        repeat (2) @(negedge ref_clk);
        err_clear = 1'b0;
        chk_val("error cleared in run", 16'h0, {14'h0, timeout_err});
        $display("test timeout done");
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            mem = {4'h0, (lfsr[3:0] == 4'hf) ? 4'he : lfsr[3:0]};
            go(8'h10, 16'h10, lfsr[31:16], 16'h0, mem, lfsr[19:4], 8'h00);
            rd({1'b0, mem[3:0]}, lfsr[19:4]);
        end
        $display("test random writes done");
        print_verdict;
    end
endmodule : testbench
